// *** design/sar_seq_ctrl.sv ***
// Sequencer, trigger, result store and monitors for an 8-channel SAR converter
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Clock source chosen, divided by divisor plus one
// - Single mode converts selected channel once
// - Single completion sets done flag, interrupt
// - Start bit high while busy, auto-cleared except in continuous mode
// - Single mode takes lowest enabled channel only
// - Scan converts enabled channels once, ascending
// - Scan done flag only after all channels
// - Cleared start: finish current, store, stop
// - Continuous restarts each pass until stopped
// - Eight-bit mask selects scanned channels
// - Pin triggers scan when source is 00b
// - Pin condition: falling, rising, low, high
// - Level held 8 clocks starts on 9th
// - Edge needs 4-clock high and low states
// - PWM triggers scan when source is 11b
// - Monitor picks channel, sense, 12-bit threshold
// - Match increments counter, mismatch clears it
// - Counter at field plus one sets flag
// - One interrupt from flags and enables
// - Result valid set on store, read clears
// - Unread overwrite sets overrun, read clears
// - Result 16 bits, zero or sign extended
module sar_seq_ctrl
#(
    parameter int NUM_CH = 8
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register port
    input wire sar_seq_pkg::reg_req_type reg_req,
    output logic [sar_seq_pkg::DATA_W-1:0] reg_rdata,
    // Clock sources, one tick per source period
    input wire logic [3:0] clk_src_tick,
    // Analog core
    output sar_seq_pkg::core_req_type core_req,
    input wire logic core_done,
    input wire logic [sar_seq_pkg::RES_W-1:0] core_result,
    // Triggers
    input wire logic ext_trigger_pin,
    input wire logic pwm_trig,
    input wire logic basic_pwm_trig,
    // Interrupt
    output logic conv_irq
);
    import sar_seq_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_LAUNCH, ST_BUSY} conv_state_type;

    // Lowest enabled channel at or above a position
    function automatic logic [CH_W:0] find_chan(input logic [NUM_CH-1:0] mask,
                                               input logic [CH_W:0] from);
        logic [CH_W:0] res;
        res = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (mask[i] && (i >= int'(from)))
                res = {1'b1, CH_W'(i)};
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [DATA_W-1:0] ctrl_r;
    logic [NUM_CH-1:0] channel_enable_mask;
    logic [DATA_W-1:0] mon_cfg_r [2];
    logic [DATA_W-1:0] clkcfg_r;
    logic conv_start_bit;
    logic conv_done_flag;
    logic [1:0] mon_flag_r;
    result_entry_type result_r [NUM_CH];
    conv_state_type state_r;
    logic [CH_W-1:0] chan_r;
    logic pass_end, hw_trig, store;
    logic [1:0] mon_hit;

    wire wr_ctrl = reg_req.wr && reg_req.addr == OFS_CTRL;
    wire wr_status = reg_req.wr && reg_req.addr == OFS_STATUS;
    wire [1:0] mode = ctrl_r[CTRL_MODE_LO +: 2];
    wire trig_en = ctrl_r[CTRL_TRIG_EN];
    wire [1:0] trig_src = ctrl_r[CTRL_TSRC_LO +: 2];
    wire [1:0] trig_cond = ctrl_r[CTRL_TCOND_LO +: 2];

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_r <= '0;
            channel_enable_mask <= '0;
            mon_cfg_r[0] <= '0;
            mon_cfg_r[1] <= '0;
            clkcfg_r <= '0;
        end
        else if (reg_req.wr)
        begin
            if (reg_req.addr == OFS_CTRL)
                ctrl_r <= reg_req.wdata;
            else if (reg_req.addr == OFS_CHANNEL_ENABLE_MASK)
                channel_enable_mask <= reg_req.wdata[NUM_CH-1:0];
            else if (reg_req.addr == OFS_MON0)
                mon_cfg_r[0] <= reg_req.wdata;
            else if (reg_req.addr == OFS_MON1)
                mon_cfg_r[1] <= reg_req.wdata;
            else if (reg_req.addr == OFS_CLKCFG)
                clkcfg_r <= reg_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter clock prescaler
    logic [7:0] div_cnt_r;
    logic conv_tick_r;
    wire src_tick = clk_src_tick[clkcfg_r[CLK_SRC_LO +: 2]];
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            div_cnt_r <= '0;
            conv_tick_r <= 1'b0;
        end
        else
        begin
            conv_tick_r <= 1'b0;
            if (src_tick)
            begin
                if (div_cnt_r >= clkcfg_r[CLK_DIV_LO +: 8])
                begin
                    div_cnt_r <= '0;
                    conv_tick_r <= 1'b1;
                end
                else
                    div_cnt_r <= div_cnt_r + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger pin: sync, level run length, edge filter
    logic pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r, prev_long_r;
    logic [3:0] run_r;
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_s3_r <= 1'b1;
        end
        else
        begin
            pin_s1_r <= ext_trigger_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pin_lvl_r <= 1'b1;
            run_r <= '0;
            prev_long_r <= 1'b0;
        end
        else if (pin_s2_r == pin_s3_r && pin_s3_r != pin_lvl_r)
        begin
            pin_lvl_r <= pin_s3_r;
            run_r <= 4'h1;
            prev_long_r <= run_r >= EDGE_MIN;
        end
        else if (run_r != RUN_MAX)
            run_r <= run_r + 4'h1;
    end

    logic pin_fire;
    always_comb
    begin
        pin_fire = 1'b0;
        if (trig_cond[1])
            // 8 clocks held, start on 9th
            pin_fire = (pin_lvl_r == trig_cond[0]) && run_r >= LEVEL_MIN;
        else
            pin_fire = prev_long_r && run_r == EDGE_MIN && pin_lvl_r == trig_cond[0];
    end

    assign hw_trig = trig_en && mode == MODE_SCAN && state_r == ST_IDLE && !conv_start_bit
        && ((trig_src == TSRC_PIN && pin_fire)
        || (trig_src == TSRC_PWM && (pwm_trig || basic_pwm_trig)));

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    wire [CH_W:0] next_hit = find_chan(channel_enable_mask, {1'b0, chan_r} + 4'h1);
    wire [CH_W:0] first_hit = find_chan(channel_enable_mask, '0);
    wire last_of_pass = mode == MODE_SINGLE || !next_hit[CH_W];
    assign store = state_r == ST_BUSY && core_done;
    assign pass_end = store && (last_of_pass || !conv_start_bit);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_r <= ST_IDLE;
            chan_r <= '0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (conv_start_bit && first_hit[CH_W])
                    begin
                        chan_r <= first_hit[CH_W-1:0];
                        state_r <= ST_LAUNCH;
                    end
                ST_LAUNCH:
                    if (conv_tick_r)
                        state_r <= ST_BUSY;
                ST_BUSY:
                    if (store)
                    begin
                        if (!conv_start_bit)
                            state_r <= ST_IDLE;
                        else if (last_of_pass && mode == MODE_CONT)
                        begin
                            chan_r <= first_hit[CH_W-1:0];
                            state_r <= ST_LAUNCH;
                        end
                        else if (last_of_pass)
                            state_r <= ST_IDLE;
                        else
                        begin
                            chan_r <= next_hit[CH_W-1:0];
                            state_r <= ST_LAUNCH;
                        end
                    end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Launch aligned to the converter clock tick
    assign core_req = '{launch: state_r == ST_LAUNCH && conv_tick_r,
                        channel: chan_r, clk_tick: conv_tick_r};

    // start bit held during run, auto-cleared except in continuous mode
    always_ff @(posedge mclk)
    begin
        if (srst)
            conv_start_bit <= 1'b0;
        else if (wr_ctrl)
            conv_start_bit <= reg_req.wdata[CTRL_START];
        else if (hw_trig)
            conv_start_bit <= 1'b1;
        else if ((pass_end && mode != MODE_CONT)
                 || (state_r == ST_IDLE && conv_start_bit && !first_hit[CH_W]))
            conv_start_bit <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Result store and read side effects
    wire rd_result = reg_req.rd && reg_req.addr <= OFS_RESULT7 && reg_req.addr[1:0] == 2'h0;
    wire [CH_W-1:0] rd_idx = reg_req.addr[CH_W+1:2];
    wire [15:0] res_ext = ctrl_r[CTRL_DIFF] ? {{4{core_result[RES_W-1]}}, core_result}
        : {4'h0, core_result};

    generate
        for (genvar g = 0; g < NUM_CH; g++)
        begin : g_res
            always_ff @(posedge mclk)
            begin
                if (srst)
                    result_r[g] <= '0;
                // per-channel store; store wins over read clear
                else if (store && chan_r == CH_W'(g))
                begin
                    result_r[g].data <= res_ext;
                    result_r[g].valid <= 1'b1;
                    result_r[g].overrun <= result_r[g].valid
                        && !(rd_result && rd_idx == CH_W'(g));
                end
                else if (rd_result && rd_idx == CH_W'(g))
                begin
                    result_r[g].valid <= 1'b0;
                    result_r[g].overrun <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Result monitors
    logic [4:0] match_cnt_r [2];
    generate
        for (genvar m = 0; m < 2; m++)
        begin : g_mon
            wire [RES_W-1:0] thr = mon_cfg_r[m][MON_THR_LO +: RES_W];
            wire ge = res_ext[RES_W-1:0] >= thr;
            wire match = mon_cfg_r[m][MON_SENSE] ? ge : !ge;
            wire [4:0] cnt_inc = match_cnt_r[m] + 5'h01;
            wire hit = store && chan_r == mon_cfg_r[m][MON_CH_LO +: CH_W];
            always_ff @(posedge mclk)
            begin
                if (srst)
                    match_cnt_r[m] <= '0;
                else if (hit)
                    match_cnt_r[m] <= match ? (match_cnt_r[m][4] ? match_cnt_r[m] : cnt_inc)
                        : 5'h00;
            end
            assign mon_hit[m] = hit && match
                && cnt_inc == {1'b0, mon_cfg_r[m][MON_CNT_LO +: 4]} + 5'h01;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Status flags, set wins over write-one clear
    logic pass_done;
    // done on single end; scan done after all
    assign pass_done = pass_end && last_of_pass;
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            conv_done_flag <= 1'b0;
            mon_flag_r <= '0;
        end
        else
        begin
            conv_done_flag <= pass_done
                || (conv_done_flag && !(wr_status && reg_req.wdata[STAT_DONE]));
            mon_flag_r <= mon_hit
                | (mon_flag_r & ~({2{wr_status}} & reg_req.wdata[STAT_MON0 +: 2]));
        end
    end

    assign conv_irq = (conv_done_flag && ctrl_r[CTRL_DONE_IE])
        || (mon_flag_r[0] && mon_cfg_r[0][MON_IE])
        || (mon_flag_r[1] && mon_cfg_r[1][MON_IE]);

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (srst)
            reg_rdata <= '0;
        else if (reg_req.rd)
        begin
            if (rd_result)
                reg_rdata <= {14'h0000, result_r[rd_idx].valid, result_r[rd_idx].overrun,
                    result_r[rd_idx].data};
            else if (reg_req.addr == OFS_CTRL)
                reg_rdata <= {ctrl_r[DATA_W-1:CTRL_START+1], conv_start_bit,
                    ctrl_r[CTRL_START-1:0]};
            else if (reg_req.addr == OFS_CHANNEL_ENABLE_MASK)
                reg_rdata <= {24'h000000, channel_enable_mask};
            else if (reg_req.addr == OFS_MON0)
                reg_rdata <= mon_cfg_r[0];
            else if (reg_req.addr == OFS_MON1)
                reg_rdata <= mon_cfg_r[1];
            else if (reg_req.addr == OFS_STATUS)
                reg_rdata <= {29'h00000000, mon_flag_r, conv_done_flag};
            else if (reg_req.addr == OFS_CLKCFG)
                reg_rdata <= clkcfg_r;
            else
                reg_rdata <= '0;
        end
        else
            reg_rdata <= '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    start_busy_a: assert property (state_r != ST_IDLE |-> conv_start_bit || store
        || $past(conv_start_bit) == 1'b0 || $past(wr_ctrl))
        else $error("start bit low during conversion");
    done_single_a: assert property (store && mode == MODE_SINGLE |=> conv_done_flag)
        else $error("single end did not set done");
    scan_partial_a: assert property (store && mode == MODE_SCAN && next_hit[CH_W]
        && conv_start_bit && !conv_done_flag && !(wr_status) |=> !conv_done_flag)
        else $error("done flag set mid scan");
    result_valid_a: assert property (store |=> result_r[$past(chan_r)].valid)
        else $error("valid not set on store");
    overrun_set_a: assert property (store && result_r[chan_r].valid && !rd_result
        |=> result_r[$past(chan_r)].overrun)
        else $error("overrun not set");
    level_trig_a: assert property (trig_en && mode == MODE_SCAN && trig_src == TSRC_PIN
        && trig_cond[1] && pin_lvl_r != trig_cond[0] ##1 (pin_lvl_r == trig_cond[0]) [*7]
        |-> !hw_trig)
        else $error("level trigger too early");
    edge_short_a: assert property (hw_trig && trig_src == TSRC_PIN && !trig_cond[1]
        |-> prev_long_r && run_r == EDGE_MIN)
        else $error("short pulse accepted");
    irq_merge_a: assert property (conv_done_flag && ctrl_r[CTRL_DONE_IE] |-> conv_irq)
        else $error("interrupt missing");
    flag_clear_a: assert property (wr_status && reg_req.wdata[STAT_DONE] && !pass_done
        |=> !conv_done_flag)
        else $error("done flag not cleared");
    stop_after_a: assert property (store && !conv_start_bit && !wr_ctrl && !hw_trig
        |=> state_r == ST_IDLE ##1 state_r == ST_IDLE)
        else $error("did not stop after clear");
    single_low_a: assert property (state_r == ST_IDLE && conv_start_bit && first_hit[CH_W]
        |=> chan_r == $past(first_hit[CH_W-1:0]))
        else $error("not lowest channel");

    scan_done_c: cover property (mode == MODE_SCAN && pass_done);
    cont_loop_c: cover property (mode == MODE_CONT && pass_done ##1 state_r == ST_LAUNCH);
    mon_flag_c: cover property (mon_hit[0]);
    pin_trig_c: cover property (hw_trig && trig_src == TSRC_PIN);
endmodule
`default_nettype wire

// *** common/sar_seq_pkg.sv ***
// Constants and types shared by the converter sequencer
package sar_seq_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int RES_W = 12;
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_RESULT0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RESULT7 = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CHANNEL_ENABLE_MASK = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_MON0 = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_MON1 = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_CLKCFG = 8'h34;
    // Control fields
    localparam int CTRL_DONE_IE = 1;
    localparam int CTRL_MODE_LO = 2;
    localparam int CTRL_TSRC_LO = 4;
    localparam int CTRL_TCOND_LO = 6;
    localparam int CTRL_TRIG_EN = 8;
    localparam int CTRL_START = 11;
    localparam int CTRL_DIFF = 31;
    // Monitor fields
    localparam int MON_IE = 1;
    localparam int MON_SENSE = 2;
    localparam int MON_CH_LO = 3;
    localparam int MON_CNT_LO = 8;
    localparam int MON_THR_LO = 16;
    // Status and result fields
    localparam int STAT_DONE = 0;
    localparam int STAT_MON0 = 1;
    localparam int RES_OVERRUN = 16;
    localparam int RES_VALID = 17;
    // Clock configuration fields
    localparam int CLK_SRC_LO = 0;
    localparam int CLK_DIV_LO = 16;
    // Trigger encodings and pin timing in peripheral clocks
    localparam logic [1:0] TSRC_PIN = 2'h0;
    localparam logic [1:0] TSRC_PWM = 2'h3;
    localparam logic [1:0] TCOND_FALL = 2'h0;
    localparam logic [1:0] TCOND_RISE = 2'h1;
    localparam logic [1:0] TCOND_LOW = 2'h2;
    localparam logic [3:0] LEVEL_MIN = 4'h8;
    localparam logic [3:0] EDGE_MIN = 4'h4;
    localparam logic [3:0] RUN_MAX = 4'hf;

    typedef enum logic [1:0] {MODE_SINGLE, MODE_RSVD, MODE_SCAN, MODE_CONT} conv_mode_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic [15:0] data;
        logic valid;
        logic overrun;
    } result_entry_type;

    typedef struct packed {
        logic launch;
        logic [CH_W-1:0] channel;
        logic clk_tick;
    } core_req_type;
endpackage

// *** verification/sar_core_model.sv ***
// Analog core stand-in: answers each launch after a set delay
`timescale 1ns/100ps
`default_nettype none
module sar_core_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Request side
    input wire sar_seq_pkg::core_req_type core_req,
    input wire logic [7:0] delay,
    input wire logic [11:0] value,
    // Answer side
    output logic core_done,
    output logic [11:0] core_result
);
    logic [7:0] cnt_r;
    logic [11:0] res_r;
    // One conversion in flight, result marked by channel
    always_ff @(posedge mclk)
    begin
        if (srst)
            cnt_r <= 8'h00;
        else if (core_req.launch)
        begin
            cnt_r <= delay + 8'h01;
            res_r <= value + {9'h000, core_req.channel};
        end
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
    end
    assign core_done = (cnt_r == 8'h01);
    // Junk outside the done cycle, so stale data is never mistaken for a result
    assign core_result = core_done ? res_r : ~res_r;
endmodule
`default_nettype wire

// *** verification/sar_seq_ctrl_tb_top.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module sar_seq_ctrl_tb_top;
    import sar_seq_pkg::*;
    typedef struct packed {logic [7:0] mask; logic [2:0] ch;} row_type;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    reg_req_type req = '0;
    core_req_type core_req;
    logic [31:0] reg_rdata, v;
    logic core_done, conv_irq, ext_pin = 1'b0, pwm_trig = 1'b0, basic_pwm_unit_trig = 1'b0;
    logic [11:0] core_result, value = 12'h123;
    logic [7:0] delay = 8'h0a;
    logic [2:0] launched[$];
    int n_fail = 0, compares = 0, t = 0;
    row_type rows[4] = '{'{8'h01, 3'h0}, '{8'h0c, 3'h2}, '{8'h80, 3'h7}, '{8'hff, 3'h0}};
    logic [2:0] order[4] = '{3'h0, 3'h2, 3'h3, 3'h7};
    logic [7:0] offs[6] = '{OFS_CTRL, OFS_CHANNEL_ENABLE_MASK, OFS_STATUS, OFS_RESULT0, OFS_MON0, 8'h40};
    always #5 mclk = ~mclk;
    sar_seq_ctrl #(.NUM_CH(8)) uut (.mclk(mclk), .srst(srst), .reg_req(req),
        .reg_rdata(reg_rdata), .clk_src_tick(4'hf), .core_req(core_req),
        .core_done(core_done), .core_result(core_result), .ext_trigger_pin(ext_pin),
        .pwm_trig(pwm_trig), .basic_pwm_trig(basic_pwm_unit_trig), .conv_irq(conv_irq));
    sar_core_model partner (.mclk(mclk), .srst(srst), .core_req(core_req), .delay(delay),
        .value(value), .core_done(core_done), .core_result(core_result));
    always @(posedge mclk)
        if (core_req.launch === 1'b1)
            launched.push_back(core_req.channel);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_idle();
        logic [31:0] c;
        c = 32'h800;
        for (int i = 0; i < 300 && c[CTRL_START]; i++)
            rd(OFS_CTRL, c);
        if (c[CTRL_START] !== 1'b0)
        begin
            n_fail++;
            complete_run();
        end
    endtask
    task automatic wait_launch(input int n);
        for (int i = 0; i < 500 && launched.size() < n; i++)
            @(posedge mclk);
        check("launch count", 32'(n), 32'(launched.size()));
        // A launch that never comes ends the run at once
        if (launched.size() < n)
            complete_run();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        foreach (offs[i])
        begin
            rd(offs[i], v);
            check("reset value", 32'h0, v);
        end
        wr(OFS_CLKCFG, 32'h0003_0000);
        repeat (40) @(posedge mclk) t += int'(core_req.clk_tick);
        check("clock ticks", 32'd10, 32'(t));
        // Single mode rows: mask in, converted channel out
        foreach (rows[i])
        begin
            launched.delete();
            wr(OFS_CHANNEL_ENABLE_MASK, {24'h0, rows[i].mask});
            wr(OFS_CTRL, 32'h802);
            rd(OFS_CTRL, v);
            check("start busy", 32'h1, {31'h0, v[CTRL_START]});
            wait_idle();
            check("single launch", {29'h0, rows[i].ch}, {29'h0, launched[0]});
            check("one launch", 32'h1, 32'(launched.size()));
            rd(OFS_STATUS, v);
            check("done flag", 32'h1, v);
            check("done irq", 32'h1, {31'h0, conv_irq});
            rd(OFS_RESULT0 + {3'h0, rows[i].ch, 2'h0}, v);
            check("result", {14'h0, 2'b10, 4'h0, value + 12'(rows[i].ch)}, v);
            wr(OFS_STATUS, 32'h1);
            rd(OFS_STATUS, v);
            check("done cleared", 32'h0, v);
            check("irq dropped", 32'h0, {31'h0, conv_irq});
        end
        // Scan over 0,2,3,7 in signed format
        value <= 12'h800;
        wr(OFS_CTRL, 32'h8000_0008);
        wr(OFS_CHANNEL_ENABLE_MASK, 32'h8d);
        launched.delete();
        wr(OFS_CTRL, 32'h8000_0808);
        wait_idle();
        foreach (order[k])
        begin
            check("scan order", {29'h0, order[k]}, {29'h0, launched[k]});
            rd(OFS_RESULT0 + {3'h0, order[k], 2'h0}, v);
            check("signed result", {14'h0, 2'b10, 4'hf, 12'h800 + 12'(order[k])}, v);
        end
        rd(OFS_RESULT0 + 8'h04, v);
        check("masked channel", 32'h0, v);
        // Unread overwrite, then monitor on channel 2
        wr(OFS_STATUS, 32'h7);
        wr(OFS_CHANNEL_ENABLE_MASK, 32'h04);
        wr(OFS_MON0, 32'h0100_0116);
        for (int k = 0; k < 2; k++)
        begin
            wr(OFS_CTRL, 32'h800);
            wait_idle();
            rd(OFS_STATUS, v);
            check("monitor flag", {31'h0, 1'b1} | {30'h0, k[0], 1'b0}, v);
        end
        check("monitor irq", 32'h1, {31'h0, conv_irq});
        rd(OFS_RESULT0 + 8'h08, v);
        check("overrun", 32'h0003_0802, v);
        rd(OFS_RESULT0 + 8'h08, v);
        check("read clears", 32'h0000_0802, v);
        wr(OFS_STATUS, 32'h2);
        rd(OFS_STATUS, v);
        check("w1c keeps done", 32'h1, v);
        // Continuous scan restarts until stopped
        wr(OFS_STATUS, 32'h7);
        wr(OFS_CHANNEL_ENABLE_MASK, 32'h05);
        launched.delete();
        wr(OFS_CTRL, 32'h80c);
        wait_launch(5);
        wr(OFS_CTRL, 32'hc);
        wait_idle();
        check("restart low", {29'h0, 3'h0}, {29'h0, launched[2]});
        rd(OFS_STATUS, v);
        check("pass done", 32'h1, v);
        // Stop mid-scan: current channel finishes and is kept
        delay <= 8'h14;
        wr(OFS_STATUS, 32'h7);
        rd(OFS_RESULT0, v);
        wr(OFS_CTRL, 32'h8);
        wr(OFS_CHANNEL_ENABLE_MASK, 32'hff);
        launched.delete();
        wr(OFS_CTRL, 32'h808);
        wait_launch(1);
        wr(OFS_CTRL, 32'h8);
        wait_idle();
        rd(OFS_RESULT0, v);
        check("kept result", 32'h1, {31'h0, v[RES_VALID]});
        check("stopped", 32'h1, 32'(launched.size()));
        // Pin rising edge: short pulse ignored, long one starts
        wr(OFS_CHANNEL_ENABLE_MASK, 32'h01);
        wr(OFS_CTRL, 32'h148);
        launched.delete();
        repeat (10) @(posedge mclk) ext_pin <= 1'b0;
        repeat (2) @(posedge mclk) ext_pin <= 1'b1;
        repeat (12) @(posedge mclk) ext_pin <= 1'b0;
        check("short pulse", 32'h0, 32'(launched.size()));
        repeat (12) @(posedge mclk) ext_pin <= 1'b1;
        wait_launch(1);
        wait_idle();
        // Both pwm sources start a scan
        wr(OFS_CTRL, 32'h138);
        for (int k = 1; k < 3; k++)
        begin
            @(posedge mclk) {basic_pwm_unit_trig, pwm_trig} <= 2'(k);
            @(posedge mclk) {basic_pwm_unit_trig, pwm_trig} <= 2'h0;
            wait_launch(k + 1);
            wait_idle();
        end
        // High level: nothing starts in the first 8 clocks of the hold, the held level then starts a scan
        repeat (12) @(posedge mclk) ext_pin <= 1'b0;
        wr(OFS_CTRL, 32'h1c8);
        repeat (8) @(posedge mclk) ext_pin <= 1'b1;
        check("level early", 32'h3, 32'(launched.size()));
        wait_launch(4);
        ext_pin <= 1'b0;
        wait_idle();
        complete_run();
    end
endmodule
`default_nettype wire
